// file: src/xpr_engine.sv
/*
 * Non-blocking read engine: two read channels filling a shared read FIFO
 * from an external device, with an AXI4-Lite register slave.
 * Assumes the external port answers each request with one rsp.valid pulse,
 * in order, and that wfifo_used comes from the write FIFO on this clock.
 */
// Chosen here: the address map and the AXI4-Lite interface to the registers.
// Operation
// [RULE_01] Two independent read channels, zero and one, usable in ping-pong.
// [RULE_02] Each channel completes a read alone, without the other configured.
// [RULE_03] Per-channel item size byte, halfword or word sets read and entry width.
// [RULE_04] Start address is relative to the device; zero is its first location.
// [RULE_05] Each channel keeps its last address until software reconfigures it.
// [RULE_06] Start takes count 1 to 4095; the channel reads exactly that many.
// [RULE_07] Start makes the channel read the device and fill the FIFO alone.
// [RULE_08] Reads pause while the FIFO is full and resume once drained.
// [RULE_09] A later start continues from the address after the last item read.
// [RULE_10] Stop aborts the transaction; no further external reads are issued.
// [RULE_11] Each channel exposes the number of items still to be read.
// [RULE_12] Each FIFO read pops and returns one item, oldest first.
// [RULE_13] The number of free write transaction FIFO entries is readable.
// [RULE_14] The number of items held in the read FIFO is readable.
// [RULE_15] A write stalled on a full write FIFO sets a clearable error flag.
// [RULE_16] Read request event is high while FIFO level exceeds the trigger.
// [RULE_17] Remaining count drops per pushed item; zero makes the channel idle.
`timescale 1ns/1ps
`default_nettype none
`include "xpr_defs.svh"

module xpr_engine #(
    parameter int FIFO_DEPTH = `XPR_FIFO_DEPTH,
    parameter int WFIFO_DEPTH = `XPR_WFIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output xpr_pkg::xpr_ext_req_t ext_req,
    input wire logic ext_req_ready,
    input wire xpr_pkg::xpr_ext_rsp_t ext_rsp,
    input wire logic [$clog2(WFIFO_DEPTH+1)-1:0] wfifo_used,
    input wire logic wfifo_write_stall,
    output logic irq
);
    import xpr_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = `XPR_COUNT_W;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] item_bytes(input xpr_size_t s);
        case (s)
            XPR_ITEM_BYTE: item_bytes = 32'h1;
            XPR_ITEM_HALF: item_bytes = 32'h2;
            default: item_bytes = 32'h4;
        endcase
    endfunction

    function automatic logic [31:0] mask_item(input xpr_size_t s, input logic [31:0] d);
        case (s)
            XPR_ITEM_BYTE: mask_item = {24'h0, d[7:0]};
            XPR_ITEM_HALF: mask_item = {16'h0, d[15:0]};
            default: mask_item = d;
        endcase
    endfunction

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic wr_fire;
    logic wr_ok;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (rst || wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
        end
    end

    always_comb begin
        case (aw_addr)
            `XPR_OFF_CFG0, `XPR_OFF_ADDR0, `XPR_OFF_START0,
            `XPR_OFF_CFG1, `XPR_OFF_ADDR1, `XPR_OFF_START1,
            `XPR_OFF_TRIG, `XPR_OFF_ENABLE, `XPR_OFF_CLEAR: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `XPR_AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `XPR_AXI_OKAY : `XPR_AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Channel registers and sequencing
    // ****************************************************************
    xpr_size_t ch_size [2];
    logic [31:0] ch_addr [2];
    logic [CW-1:0] ch_count [2];
    xpr_state_t ch_state [2];
    logic [1:0] done_pulse;
    logic [LW-1:0] level;
    logic [LW-1:0] pending;
    logic fifo_full;
    logic cur;
    logic push;
    logic pop;
    logic [31:0] fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;

    // [RULE_08] Full gate: level plus in-flight read
    assign fifo_full = (level + pending) >= LW'(FIFO_DEPTH);
    assign push = ext_rsp.valid && ch_state[cur] == XPR_WAIT;

    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            logic cfg_wr;
            logic adr_wr;
            logic go_wr;
            assign cfg_wr = wr_fire && aw_addr == (c ? `XPR_OFF_CFG1 : `XPR_OFF_CFG0);
            assign adr_wr = wr_fire && aw_addr == (c ? `XPR_OFF_ADDR1 : `XPR_OFF_ADDR0);
            assign go_wr = wr_fire && aw_addr == (c ? `XPR_OFF_START1 : `XPR_OFF_START0);

            // [RULE_03] Per-channel item size
            always_ff @(posedge clk) begin
                if (rst) begin
                    ch_size[c] <= XPR_ITEM_WORD;
                end else if (cfg_wr && w_data[1:0] != 2'h3) begin
                    ch_size[c] <= xpr_size_t'(w_data[1:0]);
                end
            end

            // [RULE_04] [RULE_05] Device-relative address, kept between starts
            always_ff @(posedge clk) begin
                if (rst) begin
                    ch_addr[c] <= 32'h0;
                end else if (adr_wr) begin
                    ch_addr[c] <= w_data;
                // [RULE_09] Advance past each item read
                end else if (push && cur == 1'(c)) begin
                    ch_addr[c] <= ch_addr[c] + item_bytes(ch_size[c]);
                end
            end

            always_ff @(posedge clk) begin
                done_pulse[c] <= 1'b0;
                if (rst) begin
                    ch_state[c] <= XPR_IDLE;
                    ch_count[c] <= '0;
                // [RULE_10] Stop aborts, no further reads
                end else if (go_wr && w_data[`XPR_START_STOP_BIT]) begin
                    ch_count[c] <= '0;
                    if (ch_state[c] != XPR_WAIT) begin
                        ch_state[c] <= XPR_IDLE;
                    end
                // [RULE_06] Count 1..4095, zero ignored
                end else if (go_wr && w_data[CW-1:0] != '0 && ch_state[c] == XPR_IDLE) begin
                    ch_count[c] <= w_data[CW-1:0];
                    ch_state[c] <= XPR_REQ;
                end else begin
                    case (ch_state[c])
                        XPR_REQ: begin
                            if (cur == 1'(c) && ext_req.valid && ext_req_ready) begin
                                ch_state[c] <= XPR_WAIT;
                            end
                        end
                        XPR_WAIT: begin
                            if (push && cur == 1'(c)) begin
                                // [RULE_17] Count down per pushed item
                                // A stopped channel lands its last item without wrapping
                                ch_count[c] <= ch_count[c] - CW'(ch_count[c] != '0);
                                if (ch_count[c] <= CW'(1)) begin
                                    ch_state[c] <= XPR_IDLE;
                                    done_pulse[c] <= ch_count[c] != '0;
                                end else begin
                                    ch_state[c] <= XPR_REQ;
                                end
                            end
                        end
                        default: ch_state[c] <= XPR_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // [RULE_01] Ping-pong: hold owner while busy, else hand over
    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= 1'b0;
        // [RULE_02] Either channel runs alone
        end else if (ch_state[cur] == XPR_IDLE && ch_state[!cur] != XPR_IDLE) begin
            cur <= !cur;
        end
    end

    // [RULE_07] Autonomous external read issue
    always_comb begin
        ext_req.valid = ch_state[cur] == XPR_REQ && !fifo_full;
        ext_req.chan = cur;
        ext_req.size = ch_size[cur];
        ext_req.addr = ch_addr[cur];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending <= '0;
        end else if (ext_req.valid && ext_req_ready) begin
            pending <= LW'(1);
        end else if (push) begin
            pending <= '0;
        end
    end

    // ****************************************************************
    // Read FIFO
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= mask_item(ch_size[cur], ext_rsp.data);
        end
    end

    // [RULE_12] Oldest first, one pop per read
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            end
            level <= level + LW'(push) - LW'(pop);
        end
    end

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    logic [`XPR_IRQ_W-1:0] status;
    logic [`XPR_IRQ_W-1:0] enable;
    logic [`XPR_IRQ_W-1:0] clr;
    logic [LW-1:0] trig;
    logic rx_req;

    // [RULE_16] Level above trigger
    assign rx_req = level > trig;
    assign clr = (wr_fire && aw_addr == `XPR_OFF_CLEAR) ? w_data[`XPR_IRQ_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            trig <= LW'(`XPR_TRIG_RST);
            enable <= '0;
        end else begin
            if (wr_fire && aw_addr == `XPR_OFF_TRIG) begin
                trig <= w_data[LW-1:0];
            end
            if (wr_fire && aw_addr == `XPR_OFF_ENABLE) begin
                enable <= w_data[`XPR_IRQ_W-1:0];
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= status & ~clr;
            status[`XPR_ST_RXREQ_BIT] <= rx_req;
            // [RULE_15] Sticky write-stall error
            if (wfifo_write_stall) begin
                status[`XPR_ST_WTFULL_BIT] <= 1'b1;
            end
            if (done_pulse[0]) begin
                status[`XPR_ST_DONE0_BIT] <= 1'b1;
            end
            if (done_pulse[1]) begin
                status[`XPR_ST_DONE1_BIT] <= 1'b1;
            end
        end
    end

    assign irq = |(status & enable);

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    logic [31:0] rd_val;

    assign s_axi_arready = !s_axi_rvalid;
    assign pop = s_axi_arvalid && s_axi_arready && s_axi_araddr == `XPR_OFF_FIFO
                 && level != '0;

    always_comb begin
        case (s_axi_araddr)
            `XPR_OFF_CFG0: rd_val = {30'h0, ch_size[0]};
            `XPR_OFF_CFG1: rd_val = {30'h0, ch_size[1]};
            `XPR_OFF_ADDR0: rd_val = ch_addr[0];
            `XPR_OFF_ADDR1: rd_val = ch_addr[1];
            // [RULE_11] Remaining items per channel
            `XPR_OFF_COUNT0: rd_val = 32'(ch_count[0]);
            `XPR_OFF_COUNT1: rd_val = 32'(ch_count[1]);
            `XPR_OFF_FIFO: rd_val = level != '0 ? fifo_mem[rd_ptr] : 32'h0;
            // [RULE_14] Items available in the read FIFO
            `XPR_OFF_AVAIL: rd_val = 32'(level);
            // [RULE_13] Free write FIFO slots
            `XPR_OFF_WFREE: rd_val = 32'(WFIFO_DEPTH) - 32'(wfifo_used);
            `XPR_OFF_TRIG: rd_val = 32'(trig);
            `XPR_OFF_STATUS: rd_val = 32'(status);
            `XPR_OFF_ENABLE: rd_val = 32'(enable);
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `XPR_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= (s_axi_araddr > `XPR_OFF_ENABLE || s_axi_araddr[1:0] != 2'h0)
                           ? `XPR_AXI_SLVERR : `XPR_AXI_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // xpr_engine
`default_nettype wire

// file: include/xpr_defs.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * external port non-blocking read engine.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef XPR_DEFS_SVH
`define XPR_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define XPR_OFF_CFG0      8'h00
`define XPR_OFF_ADDR0     8'h04
`define XPR_OFF_START0    8'h08
`define XPR_OFF_COUNT0    8'h0c
`define XPR_OFF_CFG1      8'h10
`define XPR_OFF_ADDR1     8'h14
`define XPR_OFF_START1    8'h18
`define XPR_OFF_COUNT1    8'h1c
`define XPR_OFF_FIFO      8'h20
`define XPR_OFF_AVAIL     8'h24
`define XPR_OFF_WFREE     8'h28
`define XPR_OFF_TRIG      8'h2c
`define XPR_OFF_STATUS    8'h30
`define XPR_OFF_ENABLE    8'h34
`define XPR_OFF_CLEAR     8'h38

// ****************************************************************
// Fields
// ****************************************************************
`define XPR_START_STOP_BIT 31
`define XPR_COUNT_W        12
`define XPR_ST_RXREQ_BIT   0
`define XPR_ST_WTFULL_BIT  1
`define XPR_ST_DONE0_BIT   2
`define XPR_ST_DONE1_BIT   3
`define XPR_IRQ_W          4
`define XPR_SIZE_BYTE      2'h0
`define XPR_SIZE_HALF      2'h1
`define XPR_SIZE_WORD      2'h2

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define XPR_FIFO_DEPTH     8
`define XPR_WFIFO_DEPTH    4
`define XPR_TRIG_RST       4'h4
`define XPR_AXI_OKAY       2'h0
`define XPR_AXI_SLVERR     2'h2

`endif

// file: include/xpr_pkg.sv
/*
 * Types of the external port non-blocking read engine.
 * Assumes xpr_defs.svh is on the include path.
 */
`include "xpr_defs.svh"

package xpr_pkg;

    typedef enum logic [1:0] {
        XPR_ITEM_BYTE = `XPR_SIZE_BYTE,
        XPR_ITEM_HALF = `XPR_SIZE_HALF,
        XPR_ITEM_WORD = `XPR_SIZE_WORD
    } xpr_size_t;

    typedef enum logic [1:0] {
        XPR_IDLE = 2'b00,
        XPR_REQ = 2'b01,
        XPR_WAIT = 2'b11
    } xpr_state_t;

    // External read request towards the parallel port
    typedef struct packed {
        logic valid;
        logic chan;
        xpr_size_t size;
        logic [31:0] addr;
    } xpr_ext_req_t;

    // External read answer
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } xpr_ext_rsp_t;

endpackage

// file: test/xpr_engine_chk.sv
/* Concurrent checks on the ports of the read engine.
   Assumes binding to xpr_engine; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module xpr_engine_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire xpr_pkg::xpr_ext_req_t ext_req,
    input wire logic ext_req_ready,
    input wire xpr_pkg::xpr_ext_rsp_t ext_rsp,
    input wire logic irq
);
    import xpr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [1:0] inflight;
    // ****************************************
    // Requests taken but not yet answered
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            inflight <= 2'h0;
        end else begin
            inflight <= inflight + 2'(ext_req.valid && ext_req_ready) - 2'(ext_rsp.valid);
        end
    end
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read not answered");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    a_req_hold: assert property (ext_req.valid && !ext_req_ready |=> ext_req.valid && $stable(ext_req))
        else $error("request changed");
    a_one_flight: assert property (ext_req.valid |-> inflight == 2'h0)
        else $error("second request");
    a_size_legal: assert property (ext_req.valid |-> ext_req.size != 2'h3)
        else $error("illegal item size");
    a_reset_quiet: assert property (disable iff (1'h0) rst |=> !ext_req.valid && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("busy after reset");
endmodule // xpr_engine_chk
bind xpr_engine xpr_engine_chk i_xpr_engine_chk (.*);
`default_nettype wire

// file: test/xpr_ext_dev.sv
/* Model of the external device on the parallel port.
   Assumes one request at a time; slow stretches each answer. */
`timescale 1ns/1ps
`default_nettype none
module xpr_ext_dev (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire xpr_pkg::xpr_ext_req_t ext_req,
    output logic ext_req_ready,
    output xpr_pkg::xpr_ext_rsp_t ext_rsp
);
    import xpr_pkg::*;
    logic busy;
    logic [3:0] wait_cnt;
    logic [31:0] held_addr;
    assign ext_req_ready = !busy;
    // ****************************************
    // Request, wait, answer
    // ****************************************
    // data follows device address
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'h0;
            wait_cnt <= 4'h0;
            held_addr <= 32'h0;
            ext_rsp <= '0;
        end else begin
            ext_rsp.valid <= 1'h0;
            // Idle data lines keep toggling
            ext_rsp.data <= ~ext_rsp.data;
            if (!busy && ext_req.valid) begin
                busy <= 1'h1;
                held_addr <= ext_req.addr;
                wait_cnt <= slow ? 4'hc : 4'h0;
            end else if (busy && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'h0;
                ext_rsp.valid <= 1'h1;
                ext_rsp.data <= {~held_addr[7:0], held_addr[7:0] ^ 8'h5a,
                    held_addr[7:0] + 8'h33, held_addr[7:0]};
            end
        end
    end
endmodule // xpr_ext_dev
`default_nettype wire

// file: test/xpr_engine_tb.sv
/* Register-level tests of the read engine.
   Assumes the device model answers external reads. */
`timescale 1ns/1ps
`default_nettype none
`include "xpr_defs.svh"
module xpr_engine_tb;
    import xpr_pkg::*;
    logic clk = 1'h0, rst = 1'h1, slow = 1'h0, wfifo_write_stall = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq, ext_req_ready;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [2:0] wfifo_used = 3'h1;
    xpr_ext_req_t ext_req;
    xpr_ext_rsp_t ext_rsp;
    int bad_count = 0, compares = 0, n_req = 0, k, m;
    xpr_engine i_xpr_engine (.*);
    xpr_ext_dev i_xpr_ext_dev (.*);
    always #20 clk = ~clk;
    always @(negedge clk) begin
        if (ext_req.valid === 1'h1 && ext_req_ready === 1'h1) n_req++;
    end
    // ****************************************
    // Bus tasks and comparisons
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] rs);
        int n = 0;
        logic ta, tw, got = 1'h0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dw;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!got && n < 200) begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            got = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            n++;
        end
        s_axi_bready <= 1'h0;
        if (!got) bad_count++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
        int n = 0;
        logic ta, got = 1'h0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!got && n < 200) begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            dr = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'h0;
            n++;
        end
        s_axi_rready <= 1'h0;
        if (!got) bad_count++;
    endtask
    task automatic wok(input logic [7:0] a, input logic [31:0] dw);
        wr(a, dw, r);
        chk("write resp", `XPR_AXI_OKAY, r);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp,
            input logic [31:0] mask);
        rd(a, d, r);
        chk(nm, exp, d & mask);
    endtask
    task automatic pop_chk(input logic [31:0] a, input xpr_size_t sz);
        logic [31:0] p;
        p = {~a[7:0], a[7:0] ^ 8'h5a, a[7:0] + 8'h33, a[7:0]};
        p = sz == XPR_ITEM_BYTE ? p & 32'hff : sz == XPR_ITEM_HALF ? p & 32'hffff : p;
        rd(`XPR_OFF_FIFO, d, r);
        chk("fifo item", p, d);
    endtask
    task automatic wait_avail(input int lvl);
        int n;
        n = 0;
        d = 32'h0;
        while (d < lvl && n < 300) begin
            rd(`XPR_OFF_AVAIL, d, r);
            n++;
        end
        if (d < lvl) bad_count++;
    endtask
    task automatic irq_chk(input logic exp);
        @(negedge clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rchk("cfg0", `XPR_OFF_CFG0, 32'h2, 32'h3);
        rchk("count0", `XPR_OFF_COUNT0, 32'h0, 32'hfff);
        rchk("avail", `XPR_OFF_AVAIL, 32'h0, 32'hff);
        rchk("trig", `XPR_OFF_TRIG, 32'h4, 32'hf);
        rchk("wfree", `XPR_OFF_WFREE, 32'h3, 32'h7);
        rd(8'h3c, d, r);
        chk("unmapped rd", {30'h0, `XPR_AXI_SLVERR}, {30'h0, r} | d);
        wr(8'h3c, 32'h1, r);
        chk("unmapped wr", `XPR_AXI_SLVERR, r);
        wok(`XPR_OFF_CFG0, `XPR_SIZE_BYTE);
        wok(`XPR_OFF_ADDR0, 32'h0);
        wok(`XPR_OFF_START0, 32'h3);
        wait_avail(3);
        rchk("count0 end", `XPR_OFF_COUNT0, 32'h0, 32'hfff);
        for (k = 0; k < 3; k++) pop_chk(k, XPR_ITEM_BYTE);
        rchk("empty pop", `XPR_OFF_FIFO, 32'h0, 32'hffffffff);
        rchk("done0", `XPR_OFF_STATUS, 32'h4, 32'h4);
        wok(`XPR_OFF_CLEAR, 32'h4);
        rchk("done0 clr", `XPR_OFF_STATUS, 32'h0, 32'h4);
        wok(`XPR_OFF_START0, 32'h2);
        wait_avail(2);
        for (k = 3; k < 5; k++) pop_chk(k, XPR_ITEM_BYTE);
        wok(`XPR_OFF_CFG1, `XPR_SIZE_HALF);
        wok(`XPR_OFF_ADDR1, 32'h100);
        wok(`XPR_OFF_START1, 32'ha);
        wait_avail(8);
        repeat (20) @(posedge clk);
        rchk("avail full", `XPR_OFF_AVAIL, 32'h8, 32'hff);
        rchk("count1", `XPR_OFF_COUNT1, 32'h2, 32'hfff);
        rchk("rx req", `XPR_OFF_STATUS, 32'h1, 32'h1);
        wok(`XPR_OFF_ENABLE, 32'h1);
        irq_chk(1'h1);
        wok(`XPR_OFF_ENABLE, 32'h0);
        irq_chk(1'h0);
        for (k = 0; k < 10; k++) begin
            wait_avail(1);
            pop_chk(32'h100 + 2 * k, XPR_ITEM_HALF);
        end
        rchk("count1 end", `XPR_OFF_COUNT1, 32'h0, 32'hfff);
        rchk("rx req off", `XPR_OFF_STATUS, 32'h0, 32'h1);
        slow <= 1'h1;
        wok(`XPR_OFF_CFG0, `XPR_SIZE_WORD);
        wok(`XPR_OFF_ADDR0, 32'h40);
        wok(`XPR_OFF_START0, 32'hfff);
        repeat (40) @(posedge clk);
        wok(`XPR_OFF_START0, 32'h80000000);
        repeat (30) @(posedge clk);
        k = n_req;
        repeat (100) @(posedge clk);
        chk("reqs after stop", k, n_req);
        rd(`XPR_OFF_AVAIL, d, r);
        m = d;
        rchk("count0 stop", `XPR_OFF_COUNT0, 32'h0, 32'hfff);
        for (k = 0; k < m; k++) pop_chk(32'h40 + 4 * k, XPR_ITEM_WORD);
        rchk("avail drained", `XPR_OFF_AVAIL, 32'h0, 32'hff);
        slow <= 1'h0;
        wfifo_used <= 3'h3;
        rchk("wfree 1", `XPR_OFF_WFREE, 32'h1, 32'h7);
        @(posedge clk);
        wfifo_write_stall <= 1'h1;
        @(posedge clk);
        wfifo_write_stall <= 1'h0;
        rchk("wt full", `XPR_OFF_STATUS, 32'h2, 32'h2);
        wok(`XPR_OFF_ENABLE, 32'h2);
        irq_chk(1'h1);
        wok(`XPR_OFF_CLEAR, 32'h2);
        rchk("wt full clr", `XPR_OFF_STATUS, 32'h0, 32'h2);
        irq_chk(1'h0);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule // xpr_engine_tb
`default_nettype wire
